/* File: ctc_top.sv */
// Transmit FIFO and the transmit/clock control register of a CAN controller.
// Assumes a protocol engine that reports frame start, success and failure.
module ctc_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 32
) (
  input wire logic clk, // Device clock
  input wire logic rstSync, // Synchronised reset, active high release
  input wire logic flush, // Empties the buffer
  input wire logic inValid, // Word offered
  input wire logic [WIDTH-1:0] inData, // Word in
  output logic inReady, // Room for a word
  output logic outValid, // Word available
  output logic [WIDTH-1:0] outData, // Oldest word
  input wire logic outReady // Consumer takes the word
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr_q;
  logic [AW-1:0] rdPtr_q;
  logic [AW:0] count_q;
  logic push;
  logic pop;
  // Honest flags straight from the fill count
  assign inReady = (count_q != (AW+1)'(DEPTH));
  assign outValid = (count_q != '0);
  assign outData = mem[rdPtr_q];
  assign push = inValid && inReady && !flush;
  assign pop = outValid && outReady && !flush;
  // Storage carries no reset, only pointers matter
  always_ff @(posedge clk)
  begin
    if (push)
      mem[wrPtr_q] <= inData;
  end
  // Pointers and count; flush beats any push or pop in the same cycle
  always_ff @(posedge clk or negedge rstSync)
  begin
    if (!rstSync)
    begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end
    else if (flush)
    begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end
    else
    begin
      if (push)
        wrPtr_q <= (wrPtr_q == AW'(DEPTH-1)) ? '0 : wrPtr_q + AW'(1);
      if (pop)
        rdPtr_q <= (rdPtr_q == AW'(DEPTH-1)) ? '0 : rdPtr_q + AW'(1);
      count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : ctc_fifo

// How it works
// (R1) Control bit OR pin enables transmission
// (R2) Enabled: send queued messages in order until empty
// (R3) Pin drop mid-frame: finish frame, start nothing
// (R4) No enable, no single bit: hold, send nothing
// (R5) Single bit releases one message, continuous clear
// (R6) Single bit self-clears on success or one-shot start
// (R7) One-shot single: one attempt, no retransmission
// (R8) Host uses one-shot only with single bit
// (R9) Unsent one-shot message stays queued
// (R10) Host flushes queue before reloading new message
// (R11) Filter bit on enables ID filtering
// (R12) Host writes filters only in initialization mode
// (R13) Drive-off bit disables crystal output driver
// (R14) Divider codes give clock out /1/2/4/8
// (R15) Reset enters initialization mode until changed
// (R16) Whole register resets zero, fully read/write
module ctc_top
  import ctc_pkg::*;
#(
  parameter int WIDTH = ctc_pkg::MSG_WIDTH,
  parameter int DEPTH = ctc_pkg::TX_FIFO_DEPTH
) (
  input wire logic clk, // Device clock, 20 MHz
  input wire logic rst_n, // Asynchronous reset, active low
  input wire logic cmdValid, // One host command this cycle
  input wire logic [7:0] cmdOpcode, // Command op-code
  input wire logic [7:0] cmdWrData, // Data for register writes
  output logic [7:0] cmdRdData, // Read answer, registered
  input wire logic transmitGoPin, // External transmit enable pin
  input wire logic msgValid, // Message offered to the queue
  input wire logic [WIDTH-1:0] msgData, // Message word
  output logic msgReady, // Queue has room
  output logic txRequest, // Frame waiting for the engine
  output logic [WIDTH-1:0] txData, // Frame being sent
  output logic txNoRetry, // Engine must not retransmit
  input wire logic txStarted, // Engine began the frame, pulse
  input wire logic txSuccess, // Frame sent and acknowledged, pulse
  input wire logic txFailed, // One-shot attempt lost or errored, pulse
  output logic idFilterOn, // Receive ID filtering enabled
  output logic crystalOutEn, // Crystal output pin driver enable
  output logic clockOutPin, // Divided clock output
  output logic [2:0] operatingModeSelect, // Current mode code
  output logic initMode // Initialization mode active
);
  import ctc_pkg::*;
  logic rstMeta_q;
  logic rstSync;
  logic [7:0] ctrl_q;
  logic [2:0] mode_q;
  ctc_state_t state_q;
  logic singleLaunch_q;
  logic oneShot_q;
  logic [2:0] divCnt_q;
  logic qValid;
  logic qPop;
  logic ctrlWr;
  logic txEnable;
  logic singleArmed;
  logic launch;
  logic singleClear;
  // Reset leaves through two flops so release is clean on clk
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rstMeta_q <= 1'b0;
      rstSync <= 1'b0;
    end
    else
    begin
      rstMeta_q <= 1'b1;
      rstSync <= rstMeta_q;
    end
  end

  ctc_fifo #(.WIDTH(WIDTH), .DEPTH(DEPTH)) txQueue (
    .clk(clk),
    .rstSync(rstSync),
    .flush(cmdValid && cmdOpcode == OP_TX_FLUSH),
    .inValid(msgValid),
    .inData(msgData),
    .inReady(msgReady),
    .outValid(qValid),
    .outData(txData),
    .outReady(qPop)
  );

  // Launch decision; the single bit only matters while continuous is off
  assign ctrlWr = cmdValid && cmdOpcode == OP_CTRL_WR;
  assign txEnable = ctrl_q[BIT_TRANSMIT_GO] | transmitGoPin; // R1
  assign singleArmed = ctrl_q[BIT_SEND_SINGLE_NEXT] && !ctrl_q[BIT_TRANSMIT_GO]; // R5
  assign launch = (state_q == CTC_IDLE) && qValid && (txEnable || singleArmed); // R2 R4
  // Message leaves the queue only on success, a failed one-shot keeps it
  assign qPop = (state_q == CTC_SEND) && txSuccess; // R2 R9
  // Single bit drops at success, or at start when one-shot was asked for
  assign singleClear = (state_q == CTC_SEND) && singleLaunch_q
                       && ((oneShot_q && txStarted) || txSuccess); // R6

  // Sequencer: once a frame is handed over it runs to its end
  always_ff @(posedge clk or negedge rstSync)
  begin
    if (!rstSync)
      state_q <= CTC_IDLE;
    else
      unique case (state_q)
        CTC_IDLE:
          if (launch)
            state_q <= CTC_SEND;
        CTC_SEND:
          if (txSuccess || txFailed) // R3
            state_q <= CTC_IDLE;
      endcase
  end

  // Remember how the frame was released; pin loss does not abort it
  always_ff @(posedge clk or negedge rstSync)
  begin
    if (!rstSync)
    begin
      singleLaunch_q <= 1'b0;
      oneShot_q <= 1'b0;
    end
    else if (launch)
    begin
      singleLaunch_q <= !txEnable;
      oneShot_q <= !txEnable && ctrl_q[BIT_SINGLE_ATTEMPT]; // R7
    end
  end

  // Control register; a host write in the clearing cycle wins
  always_ff @(posedge clk or negedge rstSync)
  begin
    if (!rstSync)
      ctrl_q <= CTRL_RESET; // R16
    else if (ctrlWr)
      ctrl_q <= cmdWrData; // R16
    else if (singleClear)
      ctrl_q[BIT_SEND_SINGLE_NEXT] <= 1'b0; // R6
  end

  // Mode select starts in initialization and stays until rewritten
  always_ff @(posedge clk or negedge rstSync)
  begin
    if (!rstSync)
      mode_q <= MODE_RESET; // R15
    else if (cmdValid && cmdOpcode == OP_MODE_WR)
      mode_q <= cmdWrData[2:0];
  end

  // Read answers; unknown op-codes read zero
  always_ff @(posedge clk or negedge rstSync)
  begin
    if (!rstSync)
      cmdRdData <= 8'h00;
    else if (cmdValid && cmdOpcode == OP_CTRL_RD)
      cmdRdData <= ctrl_q; // R16
    else if (cmdValid && cmdOpcode == OP_MODE_RD)
      cmdRdData <= {5'h00, mode_q};
    else if (cmdValid)
      cmdRdData <= 8'h00;
  end

  // Free running divider; bit n toggles at clk / 2^(n+1)
  always_ff @(posedge clk or negedge rstSync)
  begin
    if (!rstSync)
      divCnt_q <= 3'h0;
    else
      divCnt_q <= divCnt_q + 3'h1;
  end

  // Divide by one passes clk itself, so that path is not a flop
  always_comb
  begin
    unique case (ctrl_q[BIT_DIV_HI:BIT_DIV_LO]) // R14
      2'b00: clockOutPin = clk;
      2'b01: clockOutPin = divCnt_q[0];
      2'b10: clockOutPin = divCnt_q[1];
      2'b11: clockOutPin = divCnt_q[2];
    endcase
  end

  assign txRequest = (state_q == CTC_SEND);
  assign txNoRetry = oneShot_q; // R7
  assign idFilterOn = ctrl_q[BIT_ID_FILTER_ON]; // R11
  assign crystalOutEn = !ctrl_q[BIT_CRYSTAL_DRIVE_OFF]; // R13
  assign operatingModeSelect = mode_q;
  assign initMode = mode_q[BIT_MODE_INIT]; // R15

  property p_pin_launch;
    @(posedge clk) disable iff (!rstSync)
    (state_q == CTC_IDLE && qValid && transmitGoPin) |=> (state_q == CTC_SEND && !singleLaunch_q);
  endproperty
  a_pin_launch: assert property (p_pin_launch) else $error("pin enable did not launch"); // R1
  property p_pop_on_success;
    @(posedge clk) disable iff (!rstSync)
    (state_q == CTC_SEND && txSuccess) |-> qPop ##1 (state_q == CTC_IDLE);
  endproperty
  a_pop_on_success: assert property (p_pop_on_success) else $error("success did not dequeue"); // R2
  property p_frame_runs_on;
    @(posedge clk) disable iff (!rstSync)
    (state_q == CTC_SEND && !txSuccess && !txFailed) |=> (state_q == CTC_SEND && txRequest);
  endproperty
  a_frame_runs_on: assert property (p_frame_runs_on) else $error("frame dropped early"); // R3
  property p_hold_when_off;
    @(posedge clk) disable iff (!rstSync)
    (state_q == CTC_IDLE && !ctrl_q[7] && !transmitGoPin && !ctrl_q[6]) |=> (state_q == CTC_IDLE);
  endproperty
  a_hold_when_off: assert property (p_hold_when_off) else $error("sent while disabled"); // R4
  property p_single_release;
    @(posedge clk) disable iff (!rstSync)
    (state_q == CTC_IDLE && qValid && ctrl_q[6] && !ctrl_q[7] && !transmitGoPin)
      |=> (state_q == CTC_SEND && singleLaunch_q);
  endproperty
  a_single_release: assert property (p_single_release) else $error("single bit ignored"); // R5
  property p_single_clears;
    @(posedge clk) disable iff (!rstSync)
    (state_q == CTC_SEND && singleLaunch_q && txSuccess && !ctrlWr) |=> !ctrl_q[6];
  endproperty
  a_single_clears: assert property (p_single_clears) else $error("single bit not cleared"); // R6
  property p_one_shot;
    @(posedge clk) disable iff (!rstSync)
    (launch && ctrl_q[5] && !txEnable) |=> (txNoRetry throughout (state_q == CTC_SEND)[*1]);
  endproperty
  a_one_shot: assert property (p_one_shot) else $error("one-shot retry not blocked"); // R7
  // The failed word must still head the queue one cycle later
  property p_fail_keeps;
    @(posedge clk) disable iff (!rstSync)
    (state_q == CTC_SEND && txFailed && !txSuccess && qValid
      && !(cmdValid && cmdOpcode == OP_TX_FLUSH)) |=> (qValid && txData == $past(txData));
  endproperty
  a_fail_keeps: assert property (p_fail_keeps) else $error("failed message discarded"); // R9
  property p_readback;
    @(posedge clk) disable iff (!rstSync)
    ctrlWr ##1 (cmdValid && cmdOpcode == OP_CTRL_RD) |=> (cmdRdData == $past(cmdWrData, 2));
  endproperty
  a_readback: assert property (p_readback) else $error("control readback wrong"); // R16
endmodule : ctc_top

/* File: ctc_pkg.sv */
// Constants for the transmit and clock control register block.
// Assumes a host command decoder that hands over one op-code per command.
package ctc_pkg;
  // Command op-codes (already decoded from the host serial link)
  localparam logic [7:0] OP_CTRL_WR = 8'h16;
  localparam logic [7:0] OP_CTRL_RD = 8'hd4;
  localparam logic [7:0] OP_MODE_WR = 8'h14;
  localparam logic [7:0] OP_MODE_RD = 8'hd2;
  localparam logic [7:0] OP_TX_FLUSH = 8'h54;
  // Field positions of transmit_and_clock_control
  localparam int BIT_TRANSMIT_GO = 7;
  localparam int BIT_SEND_SINGLE_NEXT = 6;
  localparam int BIT_SINGLE_ATTEMPT = 5;
  localparam int BIT_ID_FILTER_ON = 4;
  localparam int BIT_CRYSTAL_DRIVE_OFF = 3;
  localparam int BIT_DIV_HI = 1;
  localparam int BIT_DIV_LO = 0;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  // Operating mode select, initialization is any code 1xx
  localparam int BIT_MODE_INIT = 2;
  localparam logic [2:0] MODE_RESET = 3'h4;
  // Buffer sizes
  localparam int MSG_WIDTH = 32;
  localparam int TX_FIFO_DEPTH = 32;
  // Transmit sequencer states
  typedef enum logic [1:0] {
    CTC_IDLE = 2'b01,
    CTC_SEND = 2'b10
  } ctc_state_t;
endpackage : ctc_pkg

/* File: ctc_engine_model.sv */
// Behavioural protocol engine facing the transmit side of ctc_top.
// Assumes the bench sets failNext before a one-shot frame is launched.
module ctc_engine_model (
  input wire logic clk, // Device clock
  input wire logic rst_n, // Reset, active low
  input wire logic txRequest, // Frame offered
  input wire logic txNoRetry, // No retransmission allowed
  input wire logic failNext, // Bench asks for a lost attempt
  output logic txStarted, // Frame began
  output logic txSuccess, // Frame sent
  output logic txFailed // One-shot attempt lost
);
  timeunit 1ns;
  timeprecision 100ps;
  int s = 11;
  int d;
  // Random waits model bus arbitration and frame length, so the queue sees stalls
  initial
  begin
    txStarted = 0;
    txSuccess = 0;
    txFailed = 0;
    forever
    begin
      @(posedge clk);
      if (rst_n && txRequest)
      begin
        d = 1 + ($random(s) & 3);
        repeat (d) @(posedge clk);
        #1 txStarted = 1;
        @(posedge clk);
        #1 txStarted = 0;
        d = 2 + ($random(s) & 7);
        repeat (d) @(posedge clk);
        // Retries stay hidden inside the engine unless retransmission is barred
        #1 if (failNext && txNoRetry) txFailed = 1;
        else txSuccess = 1;
        @(posedge clk);
        #1 txSuccess = 0;
        txFailed = 0;
        while (txRequest) @(posedge clk);
      end
    end
  end
endmodule : ctc_engine_model

/* File: ctc_top_tb.sv */
// Self-checking bench for ctc_top: host commands, message queue and engine.
// Assumes ctc_engine_model as the engine; inputs move 2 ns after the clock edge.
module ctc_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import ctc_pkg::*;
  logic clk = 0, rst_n = 0, cmdValid = 0, transmitGoPin = 0, msgValid = 0, failNext = 0;
  logic [7:0] cmdOpcode = 0, cmdWrData = 0, cmdRdData, d;
  logic [31:0] msgData = 0, txData;
  logic msgReady, txRequest, txNoRetry, txStarted, txSuccess, txFailed;
  logic idFilterOn, crystalOutEn, clockOutPin, initMode, rdPend = 0;
  logic [2:0] operatingModeSelect;
  logic [31:0] expFrame[$];
  logic [7:0] expRd[$];
  int seed = 66905, badCount = 0, testsRun = 0, sentCount = 0;
  realtime t0;
  always #25 clk = ~clk;
  ctc_top #(.WIDTH(32), .DEPTH(32)) u_dut (.clk(clk), .rst_n(rst_n), .cmdValid(cmdValid),
    .cmdOpcode(cmdOpcode), .cmdWrData(cmdWrData), .cmdRdData(cmdRdData),
    .transmitGoPin(transmitGoPin), .msgValid(msgValid), .msgData(msgData),
    .msgReady(msgReady), .txRequest(txRequest), .txData(txData), .txNoRetry(txNoRetry),
    .txStarted(txStarted), .txSuccess(txSuccess), .txFailed(txFailed),
    .idFilterOn(idFilterOn), .crystalOutEn(crystalOutEn), .clockOutPin(clockOutPin),
    .operatingModeSelect(operatingModeSelect), .initMode(initMode));
  ctc_engine_model u_engine (.clk(clk), .rst_n(rst_n), .txRequest(txRequest),
    .txNoRetry(txNoRetry), .failNext(failNext), .txStarted(txStarted),
    .txSuccess(txSuccess), .txFailed(txFailed));
  task automatic check(logic [31:0] got, logic [31:0] exp);
    testsRun++;
    if (got !== exp)
    begin
      badCount++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : check
  task endOfTest();
    $display("checks %0d mismatches %0d", testsRun, badCount);
    if (badCount == 0 && testsRun > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : endOfTest
  task automatic tick();
    @(posedge clk);
    #2;
  endtask : tick
  // An idle cycle after each command keeps cmdValid from being driven twice at once
  task automatic cmd(logic [7:0] op, logic [7:0] wd);
    cmdValid = 1;
    cmdOpcode = op;
    cmdWrData = wd;
    tick();
    cmdValid = 0;
    tick();
  endtask : cmd
  task automatic rd(logic [7:0] exp);
    expRd.push_back(exp);
    cmd(OP_CTRL_RD, 8'h00);
  endtask : rd
  task automatic push(logic [31:0] w);
    msgValid = 1;
    msgData = w;
    expFrame.push_back(w);
    tick();
  endtask : push
  task automatic waitSent(int n);
    for (int i = 0; i < 3000 && sentCount < n; i++)
      tick();
    check(sentCount, n);
  endtask : waitSent
  // Results are matched against the oldest note as they appear
  always @(posedge clk)
  begin
    if (rdPend) check(cmdRdData, expRd.pop_front());
    rdPend <= cmdValid && (cmdOpcode == OP_CTRL_RD || cmdOpcode == OP_MODE_RD);
    if (txSuccess)
    begin
      check(txData, expFrame.pop_front());
      sentCount++;
    end
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    badCount++;
    $display("[ERR] %0t run did not finish", $time);
    endOfTest();
  end
  initial
  begin
    repeat (12) @(posedge clk);
    #2 rst_n = 1;
    repeat (3) tick();
    check(initMode, 1);
    check(operatingModeSelect, MODE_RESET);
    rd(8'h00);
    expRd.push_back(8'(MODE_RESET));
    cmd(OP_MODE_RD, 8'h00);
    // Write then read back to back; filter and drive-off bits set while initializing
    d = (8'($random(seed)) & 8'h3f) | 8'h18;
    cmdValid = 1;
    cmdOpcode = OP_CTRL_WR;
    cmdWrData = d;
    tick();
    expRd.push_back(d);
    cmdOpcode = OP_CTRL_RD;
    tick();
    cmdValid = 0;
    tick();
    check(idFilterOn, 1);
    check(crystalOutEn, 0);
    // Measure a full output period once the divider has settled
    for (int c = 0; c < 4; c++)
    begin
      cmd(OP_CTRL_WR, 8'(c));
      repeat (2) @(posedge clockOutPin);
      t0 = $realtime;
      @(posedge clockOutPin);
      check(int'($realtime - t0), 50 << c);
      tick();
    end
    check(idFilterOn, 0);
    check(crystalOutEn, 1);
    // Fill the queue to refusal while nothing may send, then drain it
    for (int i = 0; i < 32; i++)
      push(32'($random(seed)));
    check(msgReady, 0);
    msgValid = 0;
    repeat (20) tick();
    check(txRequest, 0);
    transmitGoPin = 1;
    waitSent(32);
    transmitGoPin = 0;
    for (int i = 0; i < 3; i++)
      push(32'($random(seed)));
    msgValid = 0;
    transmitGoPin = 1;
    for (int i = 0; i < 200 && txStarted !== 1; i++)
      tick();
    transmitGoPin = 0;
    waitSent(33);
    repeat (40) tick();
    check(sentCount, 33);
    cmd(OP_CTRL_WR, 8'h40);
    waitSent(34);
    repeat (30) tick();
    check(sentCount, 34);
    rd(8'h00);
    failNext = 1;
    cmd(OP_CTRL_WR, 8'h60);
    for (int i = 0; i < 200 && txRequest !== 1; i++)
      tick();
    check(txNoRetry, 1);
    for (int i = 0; i < 200 && txFailed !== 1; i++)
      tick();
    repeat (5) tick();
    check(txRequest, 0);
    rd(8'h20);
    failNext = 0;
    cmd(OP_CTRL_WR, 8'h40);
    waitSent(35);
    push(32'($random(seed)));
    push(32'($random(seed)));
    msgValid = 0;
    cmd(OP_TX_FLUSH, 8'h00);
    expFrame.delete();
    cmd(OP_CTRL_WR, 8'h80);
    push(32'($random(seed)));
    msgValid = 0;
    waitSent(36);
    check(initMode, 1);
    cmd(OP_MODE_WR, 8'h00);
    check(operatingModeSelect, 0);
    check(initMode, 0);
    endOfTest();
  end
endmodule : ctc_top_tb
